//--- verilog/hps_map.svh
// constants for the host port and memory pin block
`ifndef HPS_MAP_SVH
`define HPS_MAP_SVH
`define HPS_ADDR_W      20
`define HPS_DATA_W      16
`define HPS_MDATA_W     18
`define HPS_PAR_HI      17
`define HPS_PAR_LO      16
`define HPS_NUM_BANKS   4
`define HPS_IRQ_SRC     4
`define HPS_MEM_WAIT_NS 8
`define HPS_MEM_WAIT_CYC ((`HPS_MEM_WAIT_NS + 3) / 4)
`define HPS_INT_WAIT_CYC 1
`endif

//--- verilog/hps_pkg.sv
// types for the external memory banks, used by the device end and the bench
package hps_pkg;
   typedef enum logic [1:0] {
      HPS_BANK1,
      HPS_BANK2,
      HPS_BANK4
   } hps_banks_t;
   typedef enum logic [1:0] {
      HPS_BANK_1M,
      HPS_BANK_512K,
      HPS_BANK_256K,
      HPS_BANK_128K
   } hps_bank_size_t;
endpackage

//--- verilog/hps_if.sv
// pin-level carrier between host and device
`timescale 1ns/1ns
interface hps_if;
   logic        bus_strobe_mode;
   logic        cs_n;
   logic        wr_or_dir;
   logic        read_or_data_strobe_n;
   logic        external_memory_steer;
   logic [19:0] addr;
   logic [15:0] host_dout;
   logic        host_doe;
   logic [15:0] dev_dout;
   logic        dev_doe;
   logic        transfer_acknowledge;
   logic        ack_oe;
   logic        irq_n;
   logic        irq_oe;
   modport device (
      input  bus_strobe_mode, cs_n, wr_or_dir, read_or_data_strobe_n,
      input  external_memory_steer, addr, host_dout, host_doe,
      output dev_dout, dev_doe, transfer_acknowledge, ack_oe, irq_n, irq_oe
   );
   modport host (
      output bus_strobe_mode, cs_n, wr_or_dir, read_or_data_strobe_n,
      output external_memory_steer, addr, host_dout, host_doe,
      input  dev_dout, dev_doe, transfer_acknowledge, ack_oe, irq_n, irq_oe
   );
endinterface

//--- verilog/hps_device.sv
// device end: host port decode, external memory pins and interrupt
`timescale 1ns/1ns
`include "hps_map.svh"
module hps_device (
   input  wire logic                        clk,
   input  wire logic                        reset,
   hps_if.device                            hp,
   input  wire hps_pkg::hps_banks_t         banks,
   input  wire hps_pkg::hps_bank_size_t     bank_size,
   input  wire logic                        parity_en,
   input  wire logic [`HPS_IRQ_SRC-1:0]     irq_src,
   input  wire logic [`HPS_IRQ_SRC-1:0]     irq_enable,
   input  wire logic                        parity_err_clear,
   output logic                             parity_err_reg,
   output logic                             int_req_reg,
   output logic                             int_we_reg,
   output logic [`HPS_ADDR_W-1:0]           int_addr_reg,
   output logic [`HPS_DATA_W-1:0]           int_wdata_reg,
   input  wire logic [`HPS_DATA_W-1:0]      int_rdata,
   output logic [`HPS_NUM_BANKS-1:0]        mem_cs_n_reg,
   output logic                             mem_we_n_reg,
   output logic [`HPS_ADDR_W-1:0]           mem_addr_reg,
   output logic [`HPS_MDATA_W-1:0]          mem_dout_reg,
   output logic                             mem_doe_reg,
   input  wire logic [`HPS_MDATA_W-1:0]     mem_din
);
   typedef enum logic [2:0] {
      S_IDLE, S_MEM, S_INT, S_ACK, S_DONE
   } hps_dev_state_t;

   // =========================================================
   // pin synchronisers
   // =========================================================
   localparam int NS = 5;
   logic [NS-1:0] s1_reg;
   logic [NS-1:0] s2_reg;
   logic [`HPS_ADDR_W-1:0] a_s;
   logic [`HPS_DATA_W-1:0] d_s;
   logic strap_s, cs_s, wr_s, rd_s, steer_s;
   logic [15:0] wdat1_reg;
   logic [15:0] wdat2_reg;
   logic [19:0] adr1_reg;
   logic [19:0] adr2_reg;
   always_ff @(posedge clk) begin
      s1_reg <= {hp.bus_strobe_mode, hp.cs_n, hp.wr_or_dir,
                 hp.read_or_data_strobe_n, hp.external_memory_steer};
      s2_reg <= s1_reg;
      adr1_reg <= hp.addr;
      adr2_reg <= adr1_reg;
      wdat1_reg <= hp.host_dout;
      wdat2_reg <= wdat1_reg;
   end
   logic [15:0] mdin1_reg;
   logic [15:0] mdin_s;
   logic [1:0]  mpar1_reg;
   logic [1:0]  mpar_s;
   always_ff @(posedge clk) begin
      mdin1_reg <= mem_din[15:0];
      mdin_s    <= mdin1_reg;
      mpar1_reg <= mem_din[`HPS_PAR_HI:`HPS_PAR_LO];
      mpar_s    <= mpar1_reg;
   end
   assign strap_s = s2_reg[4];
   assign cs_s    = s2_reg[3];
   assign wr_s    = s2_reg[2];
   assign rd_s    = s2_reg[1];
   assign steer_s = s2_reg[0];
   assign a_s     = adr2_reg;
   assign d_s     = wdat2_reg;

   // =========================================================
   // strap capture and strobe decode
   // =========================================================
   // strap caught once after reset; later changes are ignored
   logic mode_reg;
   logic mode_valid_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_valid_reg <= 1'b0;
         mode_reg       <= 1'b1;
      end else if (!mode_valid_reg) begin
         mode_valid_reg <= 1'b1;
         mode_reg       <= strap_s;
      end
   end
   logic strobe, is_write;
   always_comb begin
      if (mode_reg) begin
         strobe   = !wr_s || !rd_s;
         is_write = !wr_s;
      end else begin
         strobe   = !rd_s;
         is_write = !wr_s;
      end
      if (cs_s)
         strobe = 1'b0;
   end

   // =========================================================
   // access sequencer
   // =========================================================
   hps_dev_state_t st_reg;
   logic [3:0]  wait_reg;
   logic        wr_reg;
   logic        ext_reg;
   logic [15:0] rdata_reg;
   logic [1:0]  bank;
   logic [1:0]  bank_raw;
   logic [19:0] maddr;
   always_comb begin
      // bank index from top meaningful address bits
      unique case (bank_size)
         hps_pkg::HPS_BANK_1M: begin
            bank_raw = 2'b00;
            maddr    = a_s;
         end
         hps_pkg::HPS_BANK_512K: begin
            bank_raw = {1'b0, a_s[19]};
            maddr    = {1'b0, a_s[18:0]};
         end
         hps_pkg::HPS_BANK_256K: begin
            bank_raw = a_s[19:18];
            maddr    = {2'b00, a_s[17:0]};
         end
         hps_pkg::HPS_BANK_128K: begin
            bank_raw = a_s[18:17];
            maddr    = {3'b000, a_s[16:0]};
         end
      endcase
      unique case (banks)
         hps_pkg::HPS_BANK2: bank = {1'b0, bank_raw[0]};
         hps_pkg::HPS_BANK4: bank = bank_raw;
         default:            bank = 2'b00;
      endcase
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg        <= S_IDLE;
         wait_reg      <= 4'h0;
         wr_reg        <= 1'b0;
         ext_reg       <= 1'b0;
         rdata_reg     <= 16'h0000;
         mem_cs_n_reg  <= 4'hf;
         mem_we_n_reg  <= 1'b1;
         mem_addr_reg  <= 20'h00000;
         mem_dout_reg  <= 18'h00000;
         mem_doe_reg   <= 1'b0;
         int_req_reg   <= 1'b0;
         int_we_reg    <= 1'b0;
         int_addr_reg  <= 20'h00000;
         int_wdata_reg <= 16'h0000;
      end else begin
         int_req_reg <= 1'b0;
         unique case (st_reg)
            S_IDLE: if (strobe && mode_valid_reg) begin
               wr_reg  <= is_write;
               ext_reg <= steer_s;
               if (steer_s) begin
                  st_reg       <= S_MEM;
                  // two extra cycles cover the memory data synchroniser
                  wait_reg     <= 4'(`HPS_MEM_WAIT_CYC + 2);
                  mem_addr_reg <= maddr;
                  mem_cs_n_reg <= ~(4'h1 << bank);
                  mem_we_n_reg <= !is_write;
                  mem_doe_reg  <= is_write;
                  mem_dout_reg <= {parity_en & ~^d_s[15:8],
                                   parity_en & ~^d_s[7:0], d_s};
               end else begin
                  st_reg        <= S_INT;
                  wait_reg      <= 4'(`HPS_INT_WAIT_CYC);
                  int_req_reg   <= 1'b1;
                  int_we_reg    <= is_write;
                  int_addr_reg  <= a_s;
                  int_wdata_reg <= d_s;
               end
            end
            S_MEM: if (wait_reg <= 4'h1) begin
               st_reg       <= S_ACK;
               mem_cs_n_reg <= 4'hf;
               mem_we_n_reg <= 1'b1;
               mem_doe_reg  <= 1'b0;
               rdata_reg    <= mdin_s;
            end else
               wait_reg <= wait_reg - 4'h1;
            S_INT: if (wait_reg <= 4'h1) begin
               st_reg    <= S_ACK;
               rdata_reg <= int_rdata;
            end else
               wait_reg <= wait_reg - 4'h1;
            S_ACK:  st_reg <= S_DONE;
            S_DONE: if (!strobe) st_reg <= S_IDLE;
         endcase
      end
   end
   // odd-parity mismatch on a captured external read
   logic par_bad;
   assign par_bad = parity_en && st_reg == S_MEM && wait_reg <= 4'h1 &&
                    !wr_reg && (mpar_s != {~^mdin_s[15:8], ~^mdin_s[7:0]});

   // =========================================================
   // host-side pin drive
   // =========================================================
   // data is registered one cycle before acknowledge so the host
   // never samples a changing bus
   always_ff @(posedge clk) begin
      if (reset) begin
         hp.dev_dout             <= 16'h0000;
         hp.dev_doe              <= 1'b0;
         hp.transfer_acknowledge <= 1'b1;
         hp.ack_oe               <= 1'b0;
      end else begin
         hp.dev_dout <= rdata_reg;
         hp.dev_doe  <= !cs_s && !wr_reg &&
                        (st_reg == S_ACK || st_reg == S_DONE) && !is_write;
         if (mode_reg) begin
            hp.ack_oe <= !cs_s;
            hp.transfer_acknowledge <= st_reg == S_DONE;
         end else begin
            hp.ack_oe <= st_reg == S_DONE;
            hp.transfer_acknowledge <= 1'b0;
         end
      end
   end

   // =========================================================
   // alarm and interrupt
   // =========================================================
   always_ff @(posedge clk) begin
      if (reset)
         parity_err_reg <= 1'b0;
      else if (par_bad)
         parity_err_reg <= 1'b1;
      else if (parity_err_clear)
         parity_err_reg <= 1'b0;
   end
   logic [`HPS_IRQ_SRC:0] src_all;
   logic [`HPS_IRQ_SRC:0] en_all;
   assign src_all = {parity_err_reg, irq_src};
   assign en_all  = {1'b1, irq_enable};
   always_ff @(posedge clk) begin
      if (reset) begin
         hp.irq_n  <= 1'b1;
         hp.irq_oe <= 1'b0;
      end else begin
         hp.irq_n  <= 1'b0;
         hp.irq_oe <= |(src_all & en_all);
      end
   end
endmodule

//--- verilog/hps_host.sv
// host end: drives word transfers in either bus convention
`timescale 1ns/1ns
`include "hps_map.svh"
module hps_host (
   input  wire logic                    clk,
   input  wire logic                    reset,
   hps_if.host                          hp,
   input  wire logic                    strobe_mode,
   input  wire logic                    req,
   input  wire logic                    req_write,
   input  wire logic                    req_ext,
   input  wire logic [`HPS_ADDR_W-1:0]  req_addr,
   input  wire logic [`HPS_DATA_W-1:0]  req_wdata,
   output logic                         busy_reg,
   output logic                         done_reg,
   output logic [`HPS_DATA_W-1:0]       rdata_reg,
   output logic                         irq_seen_reg
);
   typedef enum logic [1:0] {H_IDLE, H_WAIT, H_END} hps_host_state_t;
   hps_host_state_t st_reg;
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [15:0] d1_reg;
   logic [15:0] d2_reg;
   logic mode_reg;
   logic ack;
   always_ff @(posedge clk) begin
      s1_reg <= {hp.transfer_acknowledge, hp.ack_oe,
                 hp.irq_oe && !hp.irq_n};
      s2_reg <= s1_reg;
      d1_reg <= hp.dev_dout;
      d2_reg <= d1_reg;
   end
   // strap fixed between resets: taken at reset only
   always_ff @(posedge clk) begin
      if (reset)
         mode_reg <= strobe_mode;
   end
   assign ack = mode_reg ? (s2_reg[1] && s2_reg[2])
                         : (s2_reg[1] && !s2_reg[2]);
   always_ff @(posedge clk) begin
      if (reset) begin
         st_reg                   <= H_IDLE;
         busy_reg                 <= 1'b0;
         done_reg                 <= 1'b0;
         rdata_reg                <= 16'h0000;
         irq_seen_reg             <= 1'b0;
         hp.bus_strobe_mode       <= strobe_mode;
         hp.cs_n                  <= 1'b1;
         hp.wr_or_dir             <= 1'b1;
         hp.read_or_data_strobe_n <= 1'b1;
         hp.external_memory_steer <= 1'b0;
         hp.addr                  <= 20'h00000;
         hp.host_dout             <= 16'h0000;
         hp.host_doe              <= 1'b0;
      end else begin
         done_reg     <= 1'b0;
         irq_seen_reg <= s2_reg[0];
         unique case (st_reg)
            H_IDLE: if (req) begin
               st_reg                   <= H_WAIT;
               busy_reg                 <= 1'b1;
               hp.cs_n                  <= 1'b0;
               hp.external_memory_steer <= req_ext;
               hp.addr                  <= req_addr;
               hp.host_dout             <= req_wdata;
               hp.host_doe              <= req_write;
               if (mode_reg) begin
                  hp.wr_or_dir             <= !req_write;
                  hp.read_or_data_strobe_n <= req_write;
               end else begin
                  hp.wr_or_dir             <= !req_write;
                  hp.read_or_data_strobe_n <= 1'b0;
               end
            end
            H_WAIT: if (ack) begin
               st_reg                   <= H_END;
               rdata_reg                <= d2_reg;
               hp.wr_or_dir             <= 1'b1;
               hp.read_or_data_strobe_n <= 1'b1;
               hp.host_doe              <= 1'b0;
            end
            H_END: if (!ack) begin
               st_reg   <= H_IDLE;
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
               hp.cs_n  <= 1'b1;
            end
         endcase
      end
   end
endmodule

//--- tb/hps_chk.sv
// concurrent checks on the pins between the host and device ends
`timescale 1ns/1ns
module hps_chk (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        bus_strobe_mode,
   input wire logic        cs_n,
   input wire logic        wr_or_dir,
   input wire logic        read_or_data_strobe_n,
   input wire logic [19:0] addr,
   input wire logic        host_doe,
   input wire logic        dev_doe,
   input wire logic        transfer_acknowledge,
   input wire logic        ack_oe,
   input wire logic        irq_n,
   input wire logic        irq_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================
   // pin relations
   // release is seen through a two-stage sync, hence the run of five
   chk_ready_release:
      assert property (cs_n [*5] |-> !ack_oe)
      else $error("ready still driven while deselected");
   chk_ready_driven:
      assert property ((bus_strobe_mode && !cs_n) [*5] |-> ack_oe)
      else $error("ready not driven while selected");
   chk_dtack_low:
      assert property (!bus_strobe_mode && ack_oe |-> !transfer_acknowledge)
      else $error("acknowledge driven high in data-strobe mode");
   chk_irq_low:
      assert property (irq_oe |-> !irq_n)
      else $error("interrupt driven but not low");
   chk_idle_no_drive:
      assert property (cs_n [*5] |-> !dev_doe)
      else $error("data driven while deselected");
   chk_read_data_ack:
      assert property (!cs_n && !read_or_data_strobe_n && wr_or_dir
         && ack_oe && (transfer_acknowledge == bus_strobe_mode) |-> dev_doe)
      else $error("read acknowledged without data");
   chk_strap_fixed:
      assert property (!$past(reset) |-> $stable(bus_strobe_mode))
      else $error("bus convention strap changed");
   chk_no_contention:
      assert property (!(host_doe && dev_doe))
      else $error("both ends drive the data bus");
   chk_addr_held:
      assert property (!cs_n && !$past(cs_n) && !read_or_data_strobe_n
         && !$past(read_or_data_strobe_n) |-> $stable(addr))
      else $error("address moved during a read strobe");
   chk_ack_bounded:
      assert property (!cs_n && $fell(read_or_data_strobe_n) |-> ##[1:30]
         (ack_oe && transfer_acknowledge == bus_strobe_mode))
      else $error("read not acknowledged in time");
   chk_drive_reads:
      assert property (dev_doe |-> wr_or_dir)
      else $error("device drives data during a write");
   cov_read: cover property (!read_or_data_strobe_n && transfer_acknowledge);
   cov_write: cover property (!wr_or_dir && transfer_acknowledge);
   cov_irq: cover property (irq_oe);
endmodule

//--- tb/tb_host_port_and_sram_pins.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ns
`include "hps_map.svh"
module tb_host_port_and_sram_pins;
   logic                    clk = 1'b0;
   logic                    reset = 1'b1;
   logic                    req = 1'b0;
   logic                    req_write = 1'b0;
   logic                    req_ext = 1'b0;
   logic                    perr_clr = 1'b0;
   logic [19:0]             req_addr = 20'h0;
   logic [15:0]             req_wdata = 16'h0;
   logic [15:0]             int_rdata = 16'h0;
   logic [17:0]             mem_din;
   logic [17:0]             mem_word = 18'h0;
   logic                    strobe_mode = 1'b1;
   logic                    par_en = 1'b1;
   logic                    cap_clr = 1'b0;
   logic [3:0]              irq_src = 4'h0;
   logic [3:0]              irq_en = 4'h0;
   hps_pkg::hps_banks_t     banks = hps_pkg::HPS_BANK4;
   hps_pkg::hps_bank_size_t bsize = hps_pkg::HPS_BANK_128K;
   logic                    done, irq_seen, perr, int_req, int_we, mem_we_n;
   logic [15:0]             rdata, int_wdata, iw_cap;
   logic [19:0]             int_addr, mem_addr, ia_cap, addr_cap;
   logic [3:0]              mem_cs_n, cs_cap;
   logic [17:0]             mem_dout, dout_cap;
   logic                    we_seen, iwe_cap, doe_cap, busy, mem_doe;
   int                      fail_count = 0;
   int                      checks_done = 0;
   always #2 clk = ~clk;
   hps_if hp ();
   hps_host u_hps_host (.clk(clk), .reset(reset), .hp(hp),
      .strobe_mode(strobe_mode), .req(req), .req_write(req_write),
      .req_ext(req_ext), .req_addr(req_addr), .req_wdata(req_wdata),
      .busy_reg(busy), .done_reg(done), .rdata_reg(rdata),
      .irq_seen_reg(irq_seen));
   hps_device u_hps_device (.clk(clk), .reset(reset), .hp(hp),
      .banks(banks), .bank_size(bsize), .parity_en(par_en),
      .irq_src(irq_src), .irq_enable(irq_en), .parity_err_clear(perr_clr),
      .parity_err_reg(perr), .int_req_reg(int_req), .int_we_reg(int_we),
      .int_addr_reg(int_addr), .int_wdata_reg(int_wdata),
      .int_rdata(int_rdata), .mem_cs_n_reg(mem_cs_n),
      .mem_we_n_reg(mem_we_n), .mem_addr_reg(mem_addr),
      .mem_dout_reg(mem_dout), .mem_doe_reg(mem_doe), .mem_din(mem_din));
   hps_chk u_hps_chk (.clk(clk), .reset(reset),
      .bus_strobe_mode(hp.bus_strobe_mode), .cs_n(hp.cs_n),
      .wr_or_dir(hp.wr_or_dir),
      .read_or_data_strobe_n(hp.read_or_data_strobe_n), .addr(hp.addr),
      .host_doe(hp.host_doe), .dev_doe(hp.dev_doe),
      .transfer_acknowledge(hp.transfer_acknowledge), .ack_oe(hp.ack_oe),
      .irq_n(hp.irq_n), .irq_oe(hp.irq_oe));
   // ==========================================
   // capture of what the device puts on its far-side pins
   // memory data pins have pull-downs: a deselected bank reads as zero
   assign mem_din = (mem_cs_n != 4'hf && mem_we_n === 1'b1) ? mem_word
                                                            : 18'h00000;
   always @(posedge clk) begin
      if (cap_clr) begin
         cs_cap  <= 4'hf;
         we_seen <= 1'b0;
      end else begin
         if (mem_cs_n != 4'hf) begin
            cs_cap   <= mem_cs_n;
            addr_cap <= mem_addr;
            doe_cap  <= mem_doe;
         end
         if (mem_we_n === 1'b0) begin
            we_seen  <= 1'b1;
            dout_cap <= mem_dout;
         end
      end
      if (int_req === 1'b1) begin
         iwe_cap <= int_we;
         ia_cap <= int_addr;
         iw_cap <= int_wdata;
      end
   end
   // ==========================================
   // shared tasks
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic e,
         input logic [19:0] a, input logic [15:0] d);
      int n = 0;
      @(negedge clk);
      cap_clr = 1'b1;
      @(negedge clk);
      cap_clr = 1'b0;
      req = 1'b1;
      req_write = w;
      req_ext = e;
      req_addr = a;
      req_wdata = d;
      @(negedge clk);
      req = 1'b0;
      chk({19'h0, busy}, 20'h1);
      while (done !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      chk({19'h0, n < 200}, 20'h1);
      chk({19'h0, busy}, 20'h0);
      // let the device see the strobe released before the next one
      repeat (6) @(negedge clk);
   endtask
   task automatic wait_irq(input logic e);
      int n = 0;
      while (hp.irq_oe !== e && n < 20) begin
         @(negedge clk);
         n++;
      end
      repeat (3) @(negedge clk);
      chk(hp.irq_oe, e);
   endtask
   // ==========================================
   // scenarios
   task automatic t_internal;
      int_rdata = 16'h5aa5;
      xfer(1'b1, 1'b0, 20'h0_0246, 16'hc3e1);
      chk(iwe_cap, 1'b1);
      chk(ia_cap, 20'h0_0246);
      chk(iw_cap, 16'hc3e1);
      chk(cs_cap, 4'hf);
      xfer(1'b0, 1'b0, 20'h0_0246, 16'h0);
      chk(rdata, 16'h5aa5);
      chk(iwe_cap, 1'b0);
      chk({hp.ack_oe, hp.dev_doe, hp.cs_n}, 3'b001);
   endtask
   task automatic ext_one(input hps_pkg::hps_banks_t b,
         input hps_pkg::hps_bank_size_t s, input logic [19:0] a,
         input logic [3:0] cs, input logic [19:0] m);
      logic [15:0] d;
      d = a[15:0] ^ 16'h3c96;
      banks = b;
      bsize = s;
      xfer(1'b1, 1'b1, a, d);
      chk(cs_cap, cs);
      chk(addr_cap & m, a & m);
      chk(dout_cap, {par_en & ~^d[15:8], par_en & ~^d[7:0], d});
      chk(we_seen, 1'b1);
      chk(doe_cap, 1'b1);
   endtask
   task automatic t_ext_read;
      mem_word = {~^8'ha5, ~^8'h5a, 16'ha55a};
      xfer(1'b0, 1'b1, 20'h0_1111, 16'h0);
      chk(rdata, 16'ha55a);
      chk(we_seen, 1'b0);
      chk(doe_cap, 1'b0);
      chk(perr, 1'b0);
      mem_word[17] = ~mem_word[17];
      xfer(1'b0, 1'b1, 20'h0_1111, 16'h0);
      chk(perr, 1'b1);
      wait_irq(1'b1);
      chk(irq_seen, 1'b1);
      perr_clr = 1'b1;
      @(negedge clk);
      perr_clr = 1'b0;
      wait_irq(1'b0);
      chk(perr, 1'b0);
      chk(irq_seen, 1'b0);
   endtask
   task automatic t_irq_gate;
      irq_src = 4'h4;
      wait_irq(1'b0);
      irq_en = 4'h6;
      wait_irq(1'b1);
      chk(hp.irq_n, 1'b0);
      chk(irq_seen, 1'b1);
      irq_src = 4'h9;
      wait_irq(1'b0);
   endtask
   task automatic t_data_strobe;
      // a fresh reset is the only time the strap may move
      reset = 1'b1;
      strobe_mode = 1'b0;
      par_en = 1'b0;
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      t_internal;
      ext_one(hps_pkg::HPS_BANK4, hps_pkg::HPS_BANK_256K, 20'hc_0123,
         4'h7, 20'h3_ffff);
      // bad parity must pass unnoticed with parity off
      mem_word = {2'b00, 16'h0f0e};
      xfer(1'b0, 1'b1, 20'h0_2222, 16'h0);
      chk(rdata, 16'h0f0e);
      chk(perr, 1'b0);
   endtask
   task automatic close_out;
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk);
      reset = 1'b0;
      repeat (6) @(negedge clk);
      t_internal;
      ext_one(hps_pkg::HPS_BANK4, hps_pkg::HPS_BANK_128K, 20'h6_1234,
         4'h7, 20'h1_ffff);
      ext_one(hps_pkg::HPS_BANK4, hps_pkg::HPS_BANK_128K, 20'h2_0abc,
         4'hd, 20'h1_ffff);
      ext_one(hps_pkg::HPS_BANK2, hps_pkg::HPS_BANK_512K, 20'h8_5555,
         4'hd, 20'h7_ffff);
      ext_one(hps_pkg::HPS_BANK1, hps_pkg::HPS_BANK_1M, 20'hf_0f0f,
         4'he, 20'hf_ffff);
      t_ext_read;
      t_irq_gate;
      t_data_strobe;
      close_out;
   end
   // run is a few hundred cycles; this span is ample
   initial begin
      #200000;
      fail_count++;
      close_out;
   end
endmodule
